// File: src/atas_pkg.sv
/*
  Shared constants for the sense, seek and security command block: opcodes,
  extended codes, register offsets, status bit positions and the state type.
  Assumes nothing of its surroundings.
*/
package atas_pkg;

  // Opcodes handled here; seek matches on the upper nibble only.
  localparam logic [7:0] OP_SENSE       = 8'h03;
  localparam logic [3:0] OP_SEEK_NIB    = 4'h7;
  localparam logic [7:0] OP_ERASE_PREP  = 8'hF3;
  localparam logic [7:0] OP_ERASE_UNIT  = 8'hF4;
  localparam logic [7:0] OP_DISABLE_PW  = 8'hF6;

  // Extended codes returned by the sense command.
  localparam logic [7:0] EXT_NONE       = 8'h00;
  localparam logic [7:0] EXT_SELFTEST_OK = 8'h01;
  localparam logic [7:0] EXT_WRITE_FAIL = 8'h03;
  localparam logic [7:0] EXT_MISC       = 8'h09;
  localparam logic [7:0] EXT_ECC_UNCORR = 8'h11;
  localparam logic [7:0] EXT_ECC_CORR   = 8'h18;
  localparam logic [7:0] EXT_ABORTED    = 8'h1F;
  localparam logic [7:0] EXT_BAD_ADDR   = 8'h21;
  localparam logic [7:0] EXT_OVERFLOW   = 8'h2F;
  localparam logic [7:0] EXT_SPARE_OUT  = 8'h3A;

  // Error register bits written on a failed command.
  localparam logic [7:0] ERR_ABORT      = 8'h04;
  localparam logic [7:0] ERR_NOT_FOUND  = 8'h10;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_COMMAND    = 8'h00;
  localparam logic [7:0] OFS_DRIVE_HEAD = 8'h04;
  localparam logic [7:0] OFS_CYL_HI     = 8'h08;
  localparam logic [7:0] OFS_CYL_LO     = 8'h0C;
  localparam logic [7:0] OFS_SECTOR     = 8'h10;
  localparam logic [7:0] OFS_DATA       = 8'h14;
  localparam logic [7:0] OFS_ERROR      = 8'h18;
  localparam logic [7:0] OFS_STATUS     = 8'h1C;

  // Status register bit positions; drive/head field positions.
  localparam int ST_ERR_BIT   = 0;
  localparam int ST_DRQ_BIT   = 3;
  localparam int ST_BSY_BIT   = 7;
  localparam int ST_LOCK_BIT  = 8;
  localparam int ST_PREP_BIT  = 9;
  localparam int ST_TRIES_LSB = 10;
  localparam int DH_LBA_BIT   = 6;

  // Reset values and sector layout.
  localparam logic [2:0] UNLOCK_TRIES   = 3'h5;
  localparam logic [8:0] WORD_LAST      = 9'h0FF;
  localparam logic [8:0] PW_WORD_FIRST  = 9'h001;
  localparam logic [8:0] PW_WORD_LAST   = 9'h010;

  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_EXEC} atas_state_t;

  // True for every code in the extended code table.
  function automatic logic atas_code_known(input logic [7:0] c);
    case (c)
      8'h00, 8'h01, 8'h03, 8'h05, 8'h09, 8'h0C, 8'h10, 8'h11, 8'h14, 8'h18, 8'h1F,
      8'h21, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38,
      8'h3A, 8'h3B, 8'h3C, 8'h3E, 8'h3F: atas_code_known = 1'b1;
      default: atas_code_known = 1'b0;
    endcase
  endfunction : atas_code_known

endpackage : atas_pkg

// File: src/atas_range_check.sv
/*
  Address range check for the seek command, in block or cylinder/head form.
  Assumes the limits come steady from the card controller.
*/
`timescale 1ns/1ps
module atas_range_check
  import atas_pkg::*;
(
  // Address from the task file.
  input  wire logic        lba_mode,
  input  wire logic [3:0]  head,
  input  wire logic [15:0] cyl,
  input  wire logic [7:0]  sector,
  // Geometry limits.
  input  wire logic [27:0] max_lba,
  input  wire logic [15:0] num_cyl,
  input  wire logic [4:0]  num_heads,
  // Resulting extended code, zero when in range.
  output logic      [7:0]  code
);

  always_comb begin
    code = EXT_NONE;
    if (lba_mode) begin
      if ({head, cyl, sector} > max_lba) begin
        code = EXT_OVERFLOW;
      end
    end else if ({1'b0, head} >= num_heads) begin
      code = EXT_BAD_ADDR;
    end else if (cyl >= num_cyl) begin
      code = EXT_OVERFLOW;
    end
  end

endmodule : atas_range_check

// File: src/atas_pw_sector.sv
/*
  Collects one 256-word password sector and compares words 1 to 16 with the
  stored password chosen by bit 0 of word 0.
  Assumes words arrive one per strobe, word 0 first.
*/
`timescale 1ns/1ps
module atas_pw_sector
  import atas_pkg::*;
(
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  // Sector input.
  input  wire logic         start,
  input  wire logic         word_valid,
  input  wire logic [15:0]  word,
  // Stored passwords.
  input  wire logic [255:0] user_pw,
  input  wire logic [255:0] master_pw,
  // Result.
  output logic              done,
  output logic              match
);

  logic [8:0]   idx;
  logic         differ;
  logic         use_master;
  logic [255:0] sel_pw;
  logic [7:0]   pw_base;

  assign sel_pw  = use_master ? master_pw : user_pw;
  assign pw_base = {idx[3:0] - 4'h1, 4'h0};
  assign match   = ~differ;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      idx        <= 9'h000;
      differ     <= 1'b0;
      use_master <= 1'b0;
      done       <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start) begin
        idx    <= 9'h000;
        differ <= 1'b0;
      end else if (word_valid && !idx[8]) begin
        idx <= idx + 9'h001;
        if (idx == 9'h000) begin
          use_master <= word[0];
        end else if (idx >= PW_WORD_FIRST && idx <= PW_WORD_LAST) begin
          if (word != sel_pw[pw_base +: 16]) begin
            differ <= 1'b1;
          end
        end
        if (idx == WORD_LAST) begin
          done <= 1'b1;
        end
      end
    end
  end

endmodule : atas_pw_sector

// File: src/atas_cmd.sv
/*
  Sense, seek and security command handling behind an APB register file.
  Assumes an APB master, stored passwords and geometry from the card
  controller, and outcome reports from the logic running other commands.
*/
`timescale 1ns/1ps
module atas_cmd
  import atas_pkg::*;
(
  // Clock, reset, enable.
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  // APB slave.
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // Security store.
  input  wire logic [255:0] user_pw,
  input  wire logic [255:0] master_pw,
  input  wire logic         lock_arm,
  input  wire logic         unlock_fail,
  // Outcome of commands run elsewhere.
  input  wire logic         cmd_done,
  input  wire logic [7:0]   cmd_code,
  // Geometry.
  input  wire logic [27:0]  max_lba,
  input  wire logic [15:0]  num_cyl,
  input  wire logic [4:0]   num_heads,
  // Status out.
  output logic              lock_mode,
  output logic              erase_go,
  output logic              busy,
  output logic              data_req
);

  atas_state_t state;
  logic [7:0]  command;
  logic [7:0]  drive_head;
  logic [7:0]  cyl_hi;
  logic [7:0]  cyl_lo;
  logic [7:0]  sector;
  logic [7:0]  err_reg;
  logic [7:0]  last_code;
  logic        err_flag;
  logic        prepared;
  logic [2:0]  tries;
  logic        apb_wr;
  logic        cmd_wr;
  logic        data_wr;
  logic        mapped;
  logic        sec_start;
  logic        sec_done;
  logic        sec_match;
  logic [7:0]  range_code;
  logic        is_seek;
  logic        erase_block;
  logic        exec_ok;
  logic [31:0] next_prdata;

  assign apb_wr    = psel && penable && pready && pwrite;
  assign cmd_wr    = apb_wr && paddr == OFS_COMMAND && state == ST_IDLE;
  assign data_wr   = apb_wr && paddr == OFS_DATA && state == ST_XFER;
  assign is_seek   = pwdata[7:4] == OP_SEEK_NIB;
  assign sec_start = cmd_wr;
  // Erase unit is refused outright when not preceded by prepare or out of tries.
  assign erase_block = !prepared || tries == 3'h0;
  assign exec_ok   = state == ST_EXEC && sec_match;

  atas_range_check u_range (
    .lba_mode  (drive_head[DH_LBA_BIT]),
    .head      (drive_head[3:0]),
    .cyl       ({cyl_hi, cyl_lo}),
    .sector    (sector),
    .max_lba   (max_lba),
    .num_cyl   (num_cyl),
    .num_heads (num_heads),
    .code      (range_code)
  );

  atas_pw_sector u_sector (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .start      (sec_start),
    .word_valid (data_wr),
    .word       (pwdata[15:0]),
    .user_pw    (user_pw),
    .master_pw  (master_pw),
    .done       (sec_done),
    .match      (sec_match)
  );

  // Bus answer: one wait state, then pready for a single cycle.
  always_comb begin
    mapped      = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      OFS_COMMAND:    next_prdata = {24'h00_0000, command};
      OFS_DRIVE_HEAD: next_prdata = {24'h00_0000, drive_head};
      OFS_CYL_HI:     next_prdata = {24'h00_0000, cyl_hi};
      OFS_CYL_LO:     next_prdata = {24'h00_0000, cyl_lo};
      OFS_SECTOR:     next_prdata = {24'h00_0000, sector};
      OFS_DATA:       next_prdata = 32'h0000_0000;
      OFS_ERROR:      next_prdata = {24'h00_0000, err_reg};
      OFS_STATUS: begin
        next_prdata[ST_ERR_BIT]                    = err_flag;
        next_prdata[ST_DRQ_BIT]                    = data_req;
        next_prdata[ST_BSY_BIT]                    = busy;
        next_prdata[ST_LOCK_BIT]                   = lock_mode;
        next_prdata[ST_PREP_BIT]                   = prepared;
        next_prdata[ST_TRIES_LSB +: 3]             = tries;
      end
      default:        mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Task file registers written by the host; commands are ignored while busy.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      command    <= 8'h00;
      drive_head <= 8'h00;
      cyl_hi     <= 8'h00;
      cyl_lo     <= 8'h00;
      sector     <= 8'h00;
    end else if (clk_en && apb_wr && state == ST_IDLE) begin
      case (paddr)
        OFS_COMMAND:    command    <= pwdata[7:0];
        OFS_DRIVE_HEAD: drive_head <= pwdata[7:0];
        OFS_CYL_HI:     cyl_hi     <= pwdata[7:0];
        OFS_CYL_LO:     cyl_lo     <= pwdata[7:0];
        OFS_SECTOR:     sector     <= pwdata[7:0];
        default:        ;
      endcase
    end
  end

  // Command sequencing; only the password commands leave idle.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state    <= ST_IDLE;
      busy     <= 1'b0;
      data_req <= 1'b0;
    end else if (clk_en) begin
      case (state)
        ST_IDLE: begin
          if (cmd_wr && (pwdata[7:0] == OP_DISABLE_PW ||
              (pwdata[7:0] == OP_ERASE_UNIT && !erase_block))) begin
            state    <= ST_XFER;
            busy     <= 1'b1;
            data_req <= 1'b1;
          end
        end
        ST_XFER: begin
          if (sec_done) begin
            state    <= ST_EXEC;
            data_req <= 1'b0;
          end
        end
        ST_EXEC: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
        default: begin
          state    <= ST_IDLE;
          busy     <= 1'b0;
          data_req <= 1'b0;
        end
      endcase
    end
  end

  // Outcome of each command: error register, error flag and the code kept for sense.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      err_reg   <= 8'h00;
      err_flag  <= 1'b0;
      last_code <= EXT_NONE;
    end else if (clk_en) begin
      if (cmd_wr) begin
        err_reg  <= 8'h00;
        err_flag <= 1'b0;
        if (pwdata[7:0] == OP_SENSE) begin
          err_reg   <= last_code;
          last_code <= EXT_NONE;
        end else if (is_seek) begin
          last_code <= range_code;
          if (range_code != EXT_NONE) begin
            err_reg  <= ERR_NOT_FOUND;
            err_flag <= 1'b1;
          end
        end else if (pwdata[7:0] == OP_ERASE_UNIT && erase_block) begin
          err_reg   <= ERR_ABORT;
          err_flag  <= 1'b1;
          last_code <= EXT_ABORTED;
        end else if (pwdata[7:0] == OP_ERASE_PREP) begin
          last_code <= EXT_NONE;
        end
      end else if (state == ST_EXEC) begin
        if (sec_match) begin
          last_code <= EXT_NONE;
        end else begin
          err_reg   <= ERR_ABORT;
          err_flag  <= 1'b1;
          last_code <= EXT_ABORTED;
        end
      end else if (cmd_done) begin
        // Codes outside the table are folded into the miscellaneous code.
        last_code <= atas_code_known(cmd_code) ? cmd_code : EXT_MISC;
      end
    end
  end

  // Any command other than prepare clears the prepared mark.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prepared <= 1'b0;
    end else if (clk_en) begin
      if (cmd_wr) begin
        prepared <= pwdata[7:0] == OP_ERASE_PREP;
      end else if (cmd_done) begin
        prepared <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tries <= UNLOCK_TRIES;
    end else if (clk_en && unlock_fail && tries != 3'h0) begin
      tries <= tries - 3'h1;
    end
  end

  // Lock mode; arming wins over a clear in the same cycle. The master password
  // is an input only, so disabling never alters it.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lock_mode <= 1'b0;
      erase_go  <= 1'b0;
    end else if (clk_en) begin
      erase_go <= exec_ok && command == OP_ERASE_UNIT;
      if (lock_arm) begin
        lock_mode <= 1'b1;
      end else if (exec_ok) begin
        lock_mode <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence seq_cmd(logic [7:0] op);
    clk_en && cmd_wr && pwdata[7:0] == op;
  endsequence

  sequence seq_exec(logic [7:0] op);
    clk_en && state == ST_EXEC && command == op;
  endsequence

  chk_sense_code: assert property (seq_cmd(OP_SENSE) |=> err_reg == $past(last_code))
    else $error("sense did not return previous code");
  chk_sense_clear: assert property (seq_cmd(OP_SENSE) |=> last_code == EXT_NONE)
    else $error("sense outcome not recorded as no error");
  chk_seek_range: assert property (clk_en && cmd_wr && is_seek && range_code != EXT_NONE
    |=> err_flag && err_reg == ERR_NOT_FOUND && last_code == $past(range_code))
    else $error("seek out of range not flagged");
  chk_seek_nomove: assert property (clk_en && cmd_wr && is_seek |=> state == ST_IDLE && !busy)
    else $error("seek started a transfer");
  chk_one_sector: assert property (seq_cmd(OP_DISABLE_PW) |=> data_req && busy)
    else $error("disable password did not request data");
  chk_disable_unlock: assert property (seq_exec(OP_DISABLE_PW) ##0 sec_match && !lock_arm
    |=> !lock_mode && !err_flag)
    else $error("matching password left lock on");
  chk_erase_nomatch: assert property (seq_exec(OP_ERASE_UNIT) ##0 !sec_match
    |=> !erase_go && err_reg == ERR_ABORT ##1 state == ST_IDLE)
    else $error("erase with wrong password not aborted");
  chk_erase_unprep: assert property (seq_cmd(OP_ERASE_UNIT) ##0 !prepared
    |=> err_flag && state == ST_IDLE [*2])
    else $error("erase without prepare not aborted");
  chk_tries_floor: assert property (tries == 3'h0 |=> tries == 3'h0)
    else $error("try counter left zero");
  chk_code_known: assert property (atas_code_known(last_code))
    else $error("undefined extended code held");

endmodule : atas_cmd

// File: dv/atas_host_model.sv
/*
  Host model for the command block: an APB master with tasks for register
  access, command issue and password sector transfer.
  Assumes the block answers every access with pready and runs on clock.
*/
`timescale 1ns/1ps
module atas_host_model
  import atas_pkg::*;
(
  // Clock.
  input  wire logic        clock,
  // APB master.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // Released address and data lines show the inverse of their last value.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask : rd

  task automatic command(input logic [7:0] op, input logic [7:0] dh);
    wr(OFS_DRIVE_HEAD, {24'h00_0000, dh | 8'hA0});
    wr(OFS_COMMAND, {24'h00_0000, op});
  endtask : command

  // A bad password has bit 0 of every password word flipped.
  task automatic send_sector(input logic sel, input logic [255:0] pw, input logic bad);
    logic [15:0] w;
    for (int i = 0; i < 256; i++) begin
      if (i == 0) w = {15'h0000, sel};
      else if (i <= 16) w = pw[(i-1)*16 +: 16] ^ {15'h0000, bad};
      else w = 16'h0000;
      wr(OFS_DATA, {16'h0000, w});
    end
  endtask : send_sector
endmodule : atas_host_model

// File: dv/tb.sv
/*
  Self-checking testbench for the sense, seek and security command block.
  Assumes the host model drives the APB side; the bench drives the rest.
*/
`timescale 1ns/1ps
module tb;
  import atas_pkg::*;
  typedef struct packed {
    logic [7:0] kind;
    logic [7:0] a;
    logic [7:0] chi;
    logic [7:0] clo;
    logic [7:0] sec;
    logic [7:0] exp;
  } atas_row_t;
  logic         clock, sys_rst, clk_en, psel, penable, pwrite, pready, pslverr, e;
  logic         lock_arm, unlock_fail, cmd_done, lock_mode, erase_go, busy, data_req;
  logic [7:0]   paddr, cmd_code;
  logic [31:0]  pwdata, prdata, q;
  logic [255:0] user_pw, master_pw;
  logic [27:0]  max_lba;
  logic [15:0]  num_cyl;
  logic [4:0]   num_heads;
  int           n_fail = 0, n_tests = 0, n_erase = 0, cyc = 0;
  atas_row_t    r;
  // Kind 00 reports an outcome code; kind 01 is a seek with drive/head, cylinder, sector.
  atas_row_t    rows [20] = '{48'h00_00_00_00_00_00, 48'h00_01_00_00_00_01,
    48'h00_03_00_00_00_03, 48'h00_05_00_00_00_05, 48'h00_30_00_00_00_30,
    48'h00_34_00_00_00_34, 48'h00_37_00_00_00_37, 48'h00_3E_00_00_00_3E,
    48'h00_1F_00_00_00_1F, 48'h00_11_00_00_00_11, 48'h00_18_00_00_00_18,
    48'h00_3A_00_00_00_3A, 48'h00_35_00_00_00_35, 48'h00_36_00_00_00_36,
    48'h00_77_00_00_00_09, 48'h01_04_00_00_01_21, 48'h01_03_00_64_01_2F,
    48'h01_03_00_63_01_00, 48'h01_40_00_03_E8_00, 48'h01_40_00_03_E9_2F};

  atas_cmd DUT (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .user_pw(user_pw),
    .master_pw(master_pw), .lock_arm(lock_arm), .unlock_fail(unlock_fail),
    .cmd_done(cmd_done), .cmd_code(cmd_code), .max_lba(max_lba), .num_cyl(num_cyl),
    .num_heads(num_heads), .lock_mode(lock_mode), .erase_go(erase_go), .busy(busy),
    .data_req(data_req));
  atas_host_model host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  always #50 clock = ~clock;
  always @(posedge clock) begin
    if (erase_go === 1'b1) n_erase <= n_erase + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(input logic exp, input logic got);
    chk_word({31'h0000_0000, exp}, {31'h0000_0000, got});
  endtask : chk_bit
  task automatic read_err(input logic [7:0] exp);
    host.rd(OFS_ERROR, q, e);
    chk_word({24'h00_0000, exp}, q);
  endtask : read_err
  task automatic sense(input logic [7:0] exp);
    host.command(OP_SENSE, 8'h00);
    read_err(exp);
  endtask : sense
  task automatic wait_idle();
    for (int k = 0; k < 8 && busy !== 1'b0; k++) @(posedge clock);
    // One more edge lets the erase pulse counter settle before it is read.
    @(posedge clock);
    chk_bit(1'b0, busy);
  endtask : wait_idle
  task automatic pulse_arm();
    lock_arm <= 1'b1;
    @(posedge clock);
    lock_arm <= 1'b0;
    @(posedge clock);
  endtask : pulse_arm
  task automatic pulse_fail();
    unlock_fail <= 1'b1;
    @(posedge clock);
    unlock_fail <= 1'b0;
    @(posedge clock);
  endtask : pulse_fail
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    lock_arm = 1'b0;
    unlock_fail = 1'b0;
    cmd_done = 1'b0;
    cmd_code = 8'h00;
    user_pw = {8{32'hA5C3_0F1E}};
    master_pw = {8{32'h5A3C_F0E1}};
    max_lba = 28'h00003E8;
    num_cyl = 16'h0064;
    num_heads = 5'h04;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      r = rows[i];
      if (r.kind == 8'h00) begin
        cmd_code <= r.a;
        cmd_done <= 1'b1;
        @(posedge clock);
        cmd_done <= 1'b0;
      end else begin
        host.wr(OFS_CYL_HI, {24'h00_0000, r.chi});
        host.wr(OFS_CYL_LO, {24'h00_0000, r.clo});
        host.wr(OFS_SECTOR, {24'h00_0000, r.sec});
        host.command({OP_SEEK_NIB, 4'h5}, r.a);
        host.rd(OFS_STATUS, q, e);
        chk_bit(r.exp != 8'h00, q[ST_ERR_BIT]);
        if (r.exp != 8'h00) read_err(ERR_NOT_FOUND);
      end
      sense(r.exp);
    end
    $display("test table done");
    host.rd(8'h20, q, e);
    chk_word(32'h0000_0000, q);
    chk_bit(1'b1, e);
    pulse_arm();
    chk_bit(1'b1, lock_mode);
    host.command(OP_DISABLE_PW, 8'h00);
    host.rd(OFS_STATUS, q, e);
    chk_word(32'h0000_1588, q & 32'h0000_1D88);
    host.send_sector(1'b0, user_pw, 1'b0);
    wait_idle();
    chk_bit(1'b0, lock_mode);
    pulse_arm();
    host.command(OP_DISABLE_PW, 8'h00);
    host.send_sector(1'b1, master_pw, 1'b0);
    wait_idle();
    chk_bit(1'b0, lock_mode);
    pulse_arm();
    host.command(OP_DISABLE_PW, 8'h00);
    host.send_sector(1'b0, user_pw, 1'b1);
    wait_idle();
    chk_bit(1'b1, lock_mode);
    read_err(ERR_ABORT);
    sense(EXT_ABORTED);
    $display("test disable done");
    host.command(OP_ERASE_UNIT, 8'h00);
    read_err(ERR_ABORT);
    host.rd(OFS_STATUS, q, e);
    chk_bit(1'b0, q[ST_DRQ_BIT]);
    host.command(OP_ERASE_PREP, 8'h00);
    host.command({OP_SEEK_NIB, 4'h0}, 8'h00);
    host.command(OP_ERASE_UNIT, 8'h00);
    read_err(ERR_ABORT);
    host.command(OP_ERASE_PREP, 8'h00);
    host.rd(OFS_STATUS, q, e);
    chk_bit(1'b1, q[ST_PREP_BIT]);
    host.command(OP_ERASE_UNIT, 8'h00);
    host.send_sector(1'b0, user_pw, 1'b0);
    wait_idle();
    chk_word(32'h0000_0001, n_erase);
    chk_bit(1'b0, lock_mode);
    host.command(OP_ERASE_PREP, 8'h00);
    host.command(OP_ERASE_UNIT, 8'h00);
    host.send_sector(1'b1, master_pw, 1'b1);
    wait_idle();
    read_err(ERR_ABORT);
    chk_word(32'h0000_0001, n_erase);
    $display("test erase done");
    repeat (6) pulse_fail();
    host.rd(OFS_STATUS, q, e);
    chk_word(32'h0000_0000, q & 32'h0000_1C00);
    host.command(OP_ERASE_PREP, 8'h00);
    host.command(OP_ERASE_UNIT, 8'h00);
    read_err(ERR_ABORT);
    host.rd(OFS_STATUS, q, e);
    chk_bit(1'b0, q[ST_BSY_BIT]);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    host.rd(OFS_STATUS, q, e);
    chk_word(32'h0000_1400, q);
    chk_bit(1'b0, lock_mode);
    // With the clock enable low an arm pulse must leave lock mode untouched.
    clk_en <= 1'b0;
    pulse_arm();
    chk_bit(1'b0, lock_mode);
    clk_en <= 1'b1;
    pulse_arm();
    chk_bit(1'b1, lock_mode);
    $display("test tries and reset done");
    end_of_test();
  end
endmodule : tb
